// ---- common/reo_pkg.sv ----
// Package of constants and types for the residual overcurrent stages.
package reo_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_STAGE_BASE = 8'h00;
	localparam logic [7:0] ADDR_STAGE_STRIDE = 8'h10;
	localparam logic [3:0] OFS_PICKUP = 4'h0;
	localparam logic [3:0] OFS_DELAY = 4'h1;
	localparam logic [3:0] OFS_CONFIG = 4'h2;
	localparam logic [3:0] OFS_INTRMT = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_START_COUNT = 4'h5;
	localparam logic [3:0] OFS_TRIP_COUNT = 4'h6;
	localparam logic [3:0] OFS_TIME_TO_TRIP = 4'h7;
	localparam logic [7:0] ADDR_FORCE = 8'h40;
	localparam logic [7:0] ADDR_COUNT_CLEAR = 8'h41;
	localparam logic [7:0] ADDR_GROUP = 8'h42;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFG_INPUT_LSB = 0;
	localparam int CFG_INV_BIT = 2;
	localparam int CFG_BLOCK_BIT = 3;
	localparam int ST_BLOCKED_BIT = 0;
	localparam int ST_START_BIT = 1;
	localparam int ST_TRIP_BIT = 2;
	localparam int GRP_MANUAL_LSB = 0;
	localparam int GRP_SOURCE_LSB = 4;
	localparam int GRP_INDEX_LSB = 8;

	// ------------------------------------------------------------
	// Widths, limits and reset values
	// ------------------------------------------------------------
	localparam int NSTAGE = 4;
	localparam int NGROUP = 4;
	localparam int VW = 16;
	localparam logic [VW-1:0] NOMINAL = 16'h0100;
	localparam logic [VW-1:0] RES_SAT = 16'h0A00;
	localparam logic [VW+1:0] PHASE_SAT = 18'h03200;
	localparam logic [VW-1:0] PICKUP_RST = 16'h0100;
	localparam logic [15:0] DELAY_RST = 16'h0064;
	localparam logic [15:0] INTRMT_RST = 16'h0000;
	localparam logic [15:0] DELAY_MIN = 16'h0000;

	// ------------------------------------------------------------
	// Timing: one delay tick per millisecond; force timeout.
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int FORCE_TIMEOUT_S = 300;
	localparam int FORCE_TIMEOUT_MS = FORCE_TIMEOUT_S * 1000;

	typedef enum logic [1:0] {
		SRC_RES_A,
		SRC_RES_B,
		SRC_SUMMED,
		SRC_RESERVED
	} reo_src_t;

	typedef enum logic [2:0] {
		GSRC_NONE,
		GSRC_DISCRETE,
		GSRC_SOFT_IN,
		GSRC_INDICATOR,
		GSRC_SOFT_OUT
	} reo_gsrc_t;

	typedef struct packed {
		logic [VW-1:0] residual_input_a;
		logic [VW-1:0] residual_input_b;
		logic [VW-1:0] summed_phase_residual;
	} reo_meas_t;

	typedef struct packed {
		logic [VW-1:0] pickup;
		logic [15:0] delay;
		logic [15:0] intrmt;
		logic [1:0] input_sel;
		logic inverse_delay_mode;
		logic block;
	} reo_set_t;

endpackage

// ---- core/reo_stage.sv ----
// One residual overcurrent stage: pick-up, delay accumulation and counters.
module reo_stage #(
	parameter bit INV_ALLOWED = 1'b0
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [reo_pkg::VW-1:0] value,
	input wire reo_pkg::reo_set_t cfg,
	input wire logic force_on,
	input wire logic force_start,
	input wire logic force_trip,
	input wire logic count_clear,
	output logic start_reg,
	output logic trip_reg,
	output logic [15:0] start_count_reg,
	output logic [15:0] trip_count_reg,
	output logic [15:0] time_left_reg
);
	logic over;
	logic inv;
	logic [15:0] acc_reg;
	logic [15:0] idle_reg;
	logic [15:0] target;
	logic [31:0] ratio;
	logic [15:0] step;
	logic start_next;
	logic trip_next;

	assign over = !cfg.block && (value > cfg.pickup);
	assign inv = INV_ALLOWED && cfg.inverse_delay_mode;
	assign target = cfg.delay;

	// Inverse mode advances the accumulator by value/pickup per tick, so the
	// operate time shrinks as the current rises above pick-up.
	always_comb begin
		ratio = (cfg.pickup == '0) ? 32'h0000FFFF :
			({16'h0000, value} / {16'h0000, cfg.pickup});
		if (!inv) begin
			step = 16'h0001;
		end else if (ratio > 32'h0000FFFF) begin
			step = 16'hFFFF;
		end else begin
			step = (ratio[15:0] == 16'h0000) ? 16'h0001 : ratio[15:0];
		end
	end

	// Delay accumulator survives short gaps within the intermittent time.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acc_reg <= 16'h0000;
			idle_reg <= 16'h0000;
		end else if (over) begin
			idle_reg <= 16'h0000;
			if (tick && acc_reg < target) begin
				acc_reg <= ({1'b0, acc_reg} + {1'b0, step} > {1'b0, target}) ?
					target : 16'(acc_reg + step);
			end
		end else if (acc_reg != 16'h0000) begin
			if (idle_reg >= cfg.intrmt) begin
				acc_reg <= 16'h0000;
				idle_reg <= 16'h0000;
			end else if (tick) begin
				idle_reg <= 16'(idle_reg + 16'h0001);
			end
		end
	end

	always_comb begin
		start_next = over;
		trip_next = over && (acc_reg >= target);
		if (force_on) begin
			start_next = force_start;
			trip_next = force_trip;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			start_reg <= 1'b0;
			trip_reg <= 1'b0;
		end else begin
			start_reg <= start_next;
			trip_reg <= trip_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || count_clear) begin
			start_count_reg <= 16'h0000;
			trip_count_reg <= 16'h0000;
		end else begin
			if (start_next && !start_reg) begin
				start_count_reg <= 16'(start_count_reg + 16'h0001);
			end
			if (trip_next && !trip_reg) begin
				trip_count_reg <= 16'(trip_count_reg + 16'h0001);
			end
		end
	end

	// Estimated remaining ticks: definite mode exact, inverse at present rate.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			time_left_reg <= 16'h0000;
		end else if (acc_reg >= target) begin
			time_left_reg <= 16'h0000;
		end else begin
			time_left_reg <= 16'((target - acc_reg) / step);
		end
	end
endmodule

// ---- core/reo_top.sv ----
// Four-stage residual overcurrent protection with register port.
//
// Chosen here: the plain strobed port and the register addresses.
module reo_top #(
	parameter int FORCE_TICKS = reo_pkg::FORCE_TIMEOUT_MS
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire reo_pkg::reo_meas_t meas,
	input wire logic [3:0] discrete_input_n,
	input wire logic [3:0] soft_input_n,
	input wire logic [3:0] indicator_signal_n,
	input wire logic [3:0] soft_output_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic [3:0] start_out,
	output logic [3:0] trip_out
);
	// ------------------------------------------------------------
	// Settings storage: stage x group
	// ------------------------------------------------------------
	reo_pkg::reo_set_t set_mem [reo_pkg::NSTAGE][reo_pkg::NGROUP];
	logic [1:0] manual_group_reg;
	logic [2:0] group_source_reg;
	logic [1:0] group_sel_reg;
	logic [1:0] active_group;
	logic force_reg;
	logic [31:0] force_cnt_reg;
	logic [3:0] force_start_reg;
	logic [3:0] force_trip_reg;
	logic count_clear_reg;
	logic [31:0] tick_cnt_reg;
	logic tick_reg;
	logic [reo_pkg::VW-1:0] sat_a;
	logic [reo_pkg::VW-1:0] sat_b;
	logic [reo_pkg::VW-1:0] sat_sum;
	logic [reo_pkg::VW-1:0] stage_val [reo_pkg::NSTAGE];
	logic [3:0] st_start;
	logic [3:0] st_trip;
	logic [15:0] st_scnt [reo_pkg::NSTAGE];
	logic [15:0] st_tcnt [reo_pkg::NSTAGE];
	logic [15:0] st_tleft [reo_pkg::NSTAGE];
	logic [1:0] w_stage;
	logic [3:0] w_ofs;
	logic [3:0] src_bits;

	assign w_stage = addr[5:4];
	assign w_ofs = addr[3:0];

	// ------------------------------------------------------------
	// Delay tick divider
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 32'(reo_pkg::TICK_CYC - 1)) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
			tick_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Input saturation and selection
	// ------------------------------------------------------------
	// The measurement channels deliver fundamental-only magnitudes; harmonic
	// filtering sits upstream, so this block never sees the third harmonic.
	always_comb begin
		sat_a = (meas.residual_input_a > reo_pkg::RES_SAT) ?
			reo_pkg::RES_SAT : meas.residual_input_a;
		sat_b = (meas.residual_input_b > reo_pkg::RES_SAT) ?
			reo_pkg::RES_SAT : meas.residual_input_b;
		sat_sum = ({2'b00, meas.summed_phase_residual} > reo_pkg::PHASE_SAT) ?
			reo_pkg::PHASE_SAT[reo_pkg::VW-1:0] : meas.summed_phase_residual;
	end

	always_comb begin
		for (int s = 0; s < reo_pkg::NSTAGE; s++) begin
			case (set_mem[s][active_group].input_sel)
				reo_pkg::SRC_RES_B: stage_val[s] = sat_b;
				reo_pkg::SRC_SUMMED: stage_val[s] = sat_sum;
				default: stage_val[s] = sat_a;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Setting group selection
	// ------------------------------------------------------------
	always_comb begin
		case (reo_pkg::reo_gsrc_t'(group_source_reg))
			reo_pkg::GSRC_DISCRETE: src_bits = discrete_input_n;
			reo_pkg::GSRC_SOFT_IN: src_bits = soft_input_n;
			reo_pkg::GSRC_INDICATOR: src_bits = indicator_signal_n;
			reo_pkg::GSRC_SOFT_OUT: src_bits = soft_output_n;
			default: src_bits = 4'h0;
		endcase
	end

	// Any asserted source bit overrides the manual group: lowest bit wins.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			group_sel_reg <= 2'b00;
		end else if (src_bits[0]) begin
			group_sel_reg <= 2'd0;
		end else if (src_bits[1]) begin
			group_sel_reg <= 2'd1;
		end else if (src_bits[2]) begin
			group_sel_reg <= 2'd2;
		end else if (src_bits[3]) begin
			group_sel_reg <= 2'd3;
		end else begin
			group_sel_reg <= manual_group_reg;
		end
	end
	assign active_group = group_sel_reg;

	// ------------------------------------------------------------
	// Settings writes
	// ------------------------------------------------------------
	// Settings are written into the active group; password checking belongs
	// to the operator interface outside this block.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int s = 0; s < reo_pkg::NSTAGE; s++) begin
				for (int g = 0; g < reo_pkg::NGROUP; g++) begin
					set_mem[s][g].pickup <= reo_pkg::PICKUP_RST;
					set_mem[s][g].delay <= reo_pkg::DELAY_RST;
					set_mem[s][g].intrmt <= reo_pkg::INTRMT_RST;
					set_mem[s][g].input_sel <= 2'b00;
					set_mem[s][g].inverse_delay_mode <= 1'b0;
					set_mem[s][g].block <= 1'b0;
				end
			end
		end else if (wr && addr < reo_pkg::ADDR_FORCE) begin
			if (w_ofs == reo_pkg::OFS_PICKUP) begin
				set_mem[w_stage][active_group].pickup <= wdata[reo_pkg::VW-1:0];
			end else if (w_ofs == reo_pkg::OFS_DELAY) begin
				set_mem[w_stage][active_group].delay <= wdata[15:0];
			end else if (w_ofs == reo_pkg::OFS_CONFIG) begin
				set_mem[w_stage][active_group].input_sel <=
					wdata[reo_pkg::CFG_INPUT_LSB+:2];
				set_mem[w_stage][active_group].inverse_delay_mode <=
					wdata[reo_pkg::CFG_INV_BIT] && (w_stage == 2'd0);
				set_mem[w_stage][active_group].block <= wdata[reo_pkg::CFG_BLOCK_BIT];
			end else if (w_ofs == reo_pkg::OFS_INTRMT) begin
				set_mem[w_stage][active_group].intrmt <= wdata[15:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			manual_group_reg <= 2'b00;
			group_source_reg <= 3'b000;
		end else if (wr && addr == reo_pkg::ADDR_GROUP) begin
			manual_group_reg <= wdata[reo_pkg::GRP_MANUAL_LSB+:2];
			group_source_reg <= wdata[reo_pkg::GRP_SOURCE_LSB+:3];
		end
	end

	// ------------------------------------------------------------
	// Force flag, forced status and counter clear
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			force_reg <= 1'b0;
			force_cnt_reg <= 32'h00000000;
		end else if (wr && addr == reo_pkg::ADDR_FORCE) begin
			force_reg <= wdata[0];
			force_cnt_reg <= 32'h00000000;
		end else if (force_reg && tick_reg) begin
			if (force_cnt_reg >= 32'(FORCE_TICKS - 1)) begin
				force_reg <= 1'b0;
			end else begin
				force_cnt_reg <= force_cnt_reg + 32'h00000001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || !force_reg) begin
			force_start_reg <= 4'h0;
			force_trip_reg <= 4'h0;
		end else if (wr && addr < reo_pkg::ADDR_FORCE && w_ofs == reo_pkg::OFS_STATUS) begin
			force_start_reg[w_stage] <= wdata[reo_pkg::ST_START_BIT];
			force_trip_reg[w_stage] <= wdata[reo_pkg::ST_TRIP_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			count_clear_reg <= 1'b0;
		end else begin
			count_clear_reg <= wr && addr == reo_pkg::ADDR_COUNT_CLEAR && wdata[0];
		end
	end

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	for (genvar s = 0; s < reo_pkg::NSTAGE; s++) begin : g_stage
		reo_stage #(
			.INV_ALLOWED(s == 0)
		) u_stage (
			.core_clk(core_clk),
			.rstn(rstn),
			.tick(tick_reg),
			.value(stage_val[s]),
			.cfg(set_mem[s][active_group]),
			.force_on(force_reg),
			.force_start(force_start_reg[s]),
			.force_trip(force_trip_reg[s]),
			.count_clear(count_clear_reg),
			.start_reg(st_start[s]),
			.trip_reg(st_trip[s]),
			.start_count_reg(st_scnt[s]),
			.trip_count_reg(st_tcnt[s]),
			.time_left_reg(st_tleft[s])
		);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			start_out <= 4'h0;
			trip_out <= 4'h0;
		end else begin
			start_out <= st_start;
			trip_out <= st_trip;
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdata <= 32'h00000000;
		end else if (!rd) begin
			rdata <= 32'h00000000;
		end else if (addr == reo_pkg::ADDR_FORCE) begin
			rdata <= {31'h00000000, force_reg};
		end else if (addr == reo_pkg::ADDR_GROUP) begin
			rdata <= {22'h000000, active_group, 1'b0, group_source_reg, 2'b00,
				manual_group_reg};
		end else if (addr >= reo_pkg::ADDR_FORCE) begin
			rdata <= 32'h00000000;
		end else if (w_ofs == reo_pkg::OFS_PICKUP) begin
			rdata <= {16'h0000, set_mem[w_stage][active_group].pickup};
		end else if (w_ofs == reo_pkg::OFS_DELAY) begin
			rdata <= {16'h0000, set_mem[w_stage][active_group].delay};
		end else if (w_ofs == reo_pkg::OFS_CONFIG) begin
			rdata <= {28'h0000000, set_mem[w_stage][active_group].block,
				set_mem[w_stage][active_group].inverse_delay_mode,
				set_mem[w_stage][active_group].input_sel};
		end else if (w_ofs == reo_pkg::OFS_INTRMT) begin
			rdata <= {16'h0000, set_mem[w_stage][active_group].intrmt};
		end else if (w_ofs == reo_pkg::OFS_STATUS) begin
			rdata <= {29'h00000000, st_trip[w_stage], st_start[w_stage],
				set_mem[w_stage][active_group].block};
		end else if (w_ofs == reo_pkg::OFS_START_COUNT) begin
			rdata <= {16'h0000, st_scnt[w_stage]};
		end else if (w_ofs == reo_pkg::OFS_TRIP_COUNT) begin
			rdata <= {16'h0000, st_tcnt[w_stage]};
		end else if (w_ofs == reo_pkg::OFS_TIME_TO_TRIP) begin
			rdata <= {16'h0000, st_tleft[w_stage]};
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule

// ---- sim/reo_meas_model.sv ----
// Model of the residual and phase current measurement channels.
module reo_meas_model (
	input wire logic core_clk,
	input wire logic [15:0] res_a,
	input wire logic [15:0] res_b,
	input wire logic [47:0] phases,
	output reo_pkg::reo_meas_t meas
);
	timeunit 1ns;
	timeprecision 1ps;

	// The summed channel wraps like a 16-bit adder; keep phase values small.
	always_ff @(posedge core_clk) begin
		meas.residual_input_a <= res_a;
		meas.residual_input_b <= res_b;
		meas.summed_phase_residual <= phases[15:0] + phases[31:16] + phases[47:32];
	end
endmodule

// ---- sim/reo_top_asserts.sv ----
// Concurrent checks on the ports of the residual overcurrent top.
module reo_top_asserts (
	input wire logic core_clk,
	input wire logic rstn,
	input wire reo_pkg::reo_meas_t meas,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [3:0] start_out,
	input wire logic [3:0] trip_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_rdata_idle;
		!$past(rd) |-> rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero after idle cycle");
	property p_unmapped;
		rd && addr > 8'h42 |=> rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_def_only;
		rd && addr[7:4] inside {4'h1, 4'h2, 4'h3} && addr[3:0] == 4'h2 |=> !rdata[2];
	endproperty
	a_def_only: assert property (p_def_only) else $error("inverse mode on later stage");
	property p_trip_with_start;
		(trip_out & ~start_out) == 4'h0;
	endproperty
	a_trip_with_start: assert property (p_trip_with_start) else $error("trip without start");
	property p_start_cause;
		(start_out & ~$past(start_out)) != 4'h0 |->
			$past(meas) != '0 || $past(meas, 2) != '0 || $past(meas, 3) != '0;
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("start with no current");
	property p_quiet;
		(meas == '0) [*4] |-> start_out == 4'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("start held with no current");
	property p_status_mirror;
		rd && addr == 8'h14 ##1 $stable(start_out[1]) && $stable(trip_out[1]) |->
			rdata[2:1] == {trip_out[1], start_out[1]};
	endproperty
	a_status_mirror: assert property (p_status_mirror) else $error("status differs");
	property p_wr_rd;
		wr && addr == 8'h00 ##1 rd && addr == 8'h00 |=> rdata[15:0] == $past(wdata[15:0], 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("pick-up read back differs");
endmodule

bind reo_top reo_top_asserts reo_top_asserts_i (.core_clk(core_clk), .rstn(rstn), .meas(meas),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .start_out(start_out),
	.trip_out(trip_out));

// ---- sim/tb_top.sv ----
// Register-driven testbench for the residual overcurrent stages.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk, rstn, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] start_out, trip_out, dsc, sin, ind, sout;
	logic [15:0] res_a, res_b;
	logic [47:0] phases;
	reo_pkg::reo_meas_t meas;
	logic [3:0] t_s [5] = '{4'h1, 4'h2, 4'h4, 4'h1, 4'h9};
	logic [1:0] t_g [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	int mismatches, n_checks;

	reo_meas_model reo_meas_model_i (.core_clk(core_clk), .res_a(res_a), .res_b(res_b),
		.phases(phases), .meas(meas));
	reo_top #(.FORCE_TICKS(3)) reo_top_i (.core_clk(core_clk), .rstn(rstn), .meas(meas),
		.discrete_input_n(dsc), .soft_input_n(sin), .indicator_signal_n(ind),
		.soft_output_n(sout), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.start_out(start_out), .trip_out(trip_out));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// The strobe is left high so a read may follow at once; idle drops it.
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rget(input logic [7:0] a);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge core_clk);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		rget(a);
		check(v, exp);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask
	task automatic outs(input logic [3:0] s, input logic [3:0] t);
		@(negedge core_clk);
		check({28'h0, start_out}, {28'h0, s});
		check({28'h0, trip_out}, {28'h0, t});
		@(posedge core_clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rstn, wr, rd, addr, wdata, res_a, res_b, phases} = '0;
		{dsc, sin, ind, sout} = {4'h2, 4'h4, 4'h8, 4'h1};
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			rreg(8'(s * 16), 32'h0100);
			rreg(8'(s * 16 + 1), 32'h0064);
			rreg(8'(s * 16 + 2), 32'h0);
		end
		wreg(8'h50, 32'h5);
		rreg(8'h50, 32'h0);
		wreg(8'h02, 32'h4);
		rreg(8'h02, 32'h4);
		wreg(8'h12, 32'h4);
		rreg(8'h12, 32'h0);
		for (int s = 0; s < 4; s++) begin
			wreg(8'(s * 16), (s == 3) ? 32'h0200 : 32'h0080);
			rreg(8'(s * 16), (s == 3) ? 32'h0200 : 32'h0080);
			wreg(8'(s * 16 + 1), 32'h0);
			wreg(8'(s * 16 + 2), (s == 3) ? 32'h0 : 32'(s));
		end
		// Rows: input A, input B, summed phases, A at and just above pick-up.
		for (int i = 0; i < 5; i++) begin
			res_a <= (i == 0) ? 16'h0100 : (i == 3) ? 16'h0200 : (i == 4) ? 16'h0201 : 16'h0;
			res_b <= (i == 1) ? 16'h0100 : 16'h0;
			phases <= (i == 2) ? {3{16'h0040}} : 48'h0;
			idle(6);
			outs(t_s[i], t_s[i]);
		end
		res_a <= 16'h0;
		idle(6);
		outs(4'h0, 4'h0);
		wreg(8'h00, 32'h0A00);
		res_a <= 16'hFFFF;
		idle(6);
		outs(4'h8, 4'h8);
		wreg(8'h00, 32'h09FF);
		idle(6);
		outs(4'h9, 4'h9);
		res_a <= 16'h0;
		wreg(8'h41, 32'h1);
		wreg(8'h11, 32'h0064);
		for (int i = 0; i < 2; i++) begin
			res_b <= 16'h0100;
			idle(6);
			outs(4'h2, 4'h0);
			rget(8'h17);
			check({31'h0, v[15:0] >= 16'h0063 && v[15:0] <= 16'h0064}, 32'h1);
			res_b <= 16'h0;
			idle(6);
		end
		rreg(8'h15, 32'h2);
		rreg(8'h16, 32'h0);
		res_b <= 16'h0100;
		wreg(8'h14, 32'h6);
		idle(6);
		outs(4'h2, 4'h0);
		wreg(8'h40, 32'h1);
		wreg(8'h14, 32'h6);
		idle(6);
		outs(4'h2, 4'h2);
		rreg(8'h14, 32'h6);
		wreg(8'h40, 32'h0);
		idle(6);
		outs(4'h2, 4'h0);
		res_b <= 16'h0;
		wreg(8'h42, 32'h1);
		idle(2);
		rreg(8'h42, 32'h0101);
		rreg(8'h00, 32'h0100);
		for (int k = 1; k < 5; k++) begin
			wreg(8'h42, 32'(k << 4));
			idle(2);
			rreg(8'h42, 32'(k << 4) | 32'(t_g[k - 1]) << 8);
		end
		wreg(8'h42, 32'h0);
		idle(2);
		rreg(8'h42, 32'h0);
		rreg(8'h00, 32'h09FF);
		idle(2);
		print_verdict();
	end
endmodule
